// ---- common/lane_status_defines.svh ----
// Constants for the per-lane error count status bank.
`ifndef LANE_STATUS_DEFINES_SVH
`define LANE_STATUS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map (indexes; byte address is four times the index)
// ----------------------------------------------------------------------
`define LSB_LANE1_STATUS_IDX 12'h491
`define LSB_LANE2_STATUS_IDX 12'h492
`define LSB_LANE3_STATUS_IDX 12'h493
`define LSB_LANE4_STATUS_IDX 12'h494
`define LSB_LANE5_STATUS_IDX 12'h495
`define LSB_FIRST_LANE       1
`define LSB_NUM_LANES        5
`define LSB_ADDR_W           14

// ----------------------------------------------------------------------
// Field layout and values
// ----------------------------------------------------------------------
`define LSB_BIT_UNEXP_CTRL   2
`define LSB_BIT_NOT_IN_TABLE 1
`define LSB_BIT_BAD_DISP     0
`define LSB_BIT_ACTIVE       3
`define LSB_NUM_ERR          3
`define LSB_CNT_W            8
`define LSB_TERM_COUNT       8'hff
`define LSB_STATUS_RESET     8'h00

`endif

// ---- common/lane_status_pkg.sv ----
// Types shared by the lane error status bank and its counter module.
package lane_status_pkg;
  `include "lane_status_defines.svh"

  typedef logic [`LSB_NUM_ERR-1:0] err_flags_t;
  typedef logic [`LSB_CNT_W-1:0]   err_count_t;

  typedef enum logic {
    bus_idle,
    bus_ack
  } bus_state_t;

  typedef struct packed {
    err_count_t [`LSB_NUM_ERR-1:0] count;
    err_flags_t                    full;
  } err_cnt_state_t;

  typedef struct packed {
    bus_state_t                        bus;
    logic [31:0]                       readdata;
    logic [`LSB_NUM_LANES-1:0][7:0]    status;
  } bank_state_t;
endpackage

// ---- rtl/lane_err_counter.sv ----
// Three error counters of one lane with hold or rollover and terminal-count flags.
`timescale 1ns/100ps
`default_nettype none
`include "lane_status_defines.svh"
module lane_err_counter (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  // Lane side
  input  wire lane_status_pkg::err_flags_t err_event,
  input  wire lane_status_pkg::err_flags_t hold_en,
  input  wire logic                        counter_clear,
  // Flags
  output lane_status_pkg::err_flags_t      count_full
);
  import lane_status_pkg::*;

  err_cnt_state_t cur_ff;
  err_cnt_state_t nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    for (int i = 0; i < `LSB_NUM_ERR; i++) begin
      if (counter_clear) begin
        // An error in the clearing cycle still counts as the first one.
        nxt_cur.count[i] = err_event[i] ? 8'h01 : 8'h00;
      end else if (err_event[i]) begin
        if (cur_ff.count[i] == `LSB_TERM_COUNT) begin
          nxt_cur.count[i] = hold_en[i] ? `LSB_TERM_COUNT : 8'h00;
        end else begin
          nxt_cur.count[i] = cur_ff.count[i] + 8'h01;
        end
      end
      // The flag survives a wrap so that a lost terminal count is still seen.
      nxt_cur.full[i] = (!counter_clear && err_event[i]
                         && cur_ff.count[i] == (`LSB_TERM_COUNT - 8'h01))
                        || (cur_ff.full[i] && !counter_clear);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign count_full = cur_ff.full;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < `LSB_NUM_ERR; g++) begin : g_chk
    a_hold_at_term: assert property (@(posedge ref_clk) disable iff (srst)
      hold_en[g] && !counter_clear && cur_ff.count[g] == 8'hff
      |=> cur_ff.count[g] == 8'hff)
      else $error("counter left terminal count with hold enabled");
    a_wrap_to_zero: assert property (@(posedge ref_clk) disable iff (srst)
      !hold_en[g] && !counter_clear && err_event[g] && cur_ff.count[g] == 8'hff
      |=> cur_ff.count[g] == 8'h00)
      else $error("counter did not wrap to zero");
    a_flag_on_reach: assert property (@(posedge ref_clk) disable iff (srst)
      !counter_clear && err_event[g] && cur_ff.count[g] == 8'hfe
      |=> count_full[g] && cur_ff.count[g] == 8'hff)
      else $error("flag not set when count reached terminal value");
    a_flag_sticky: assert property (@(posedge ref_clk) disable iff (srst)
      count_full[g] && !counter_clear |=> count_full[g])
      else $error("flag dropped without a counter clear");
    a_flag_clears: assert property (@(posedge ref_clk) disable iff (srst)
      counter_clear |=> !count_full[g] && cur_ff.count[g] <= 8'h01)
      else $error("flag or count survived a counter clear");
  end
endmodule
`default_nettype wire

// ---- rtl/lane_status_bank.sv ----
// Read-only per-lane error status bank on an Avalon-MM slave.
`timescale 1ns/100ps
`default_nettype none
`include "lane_status_defines.svh"
module lane_status_bank #(
  parameter int NUM_LANES = `LSB_NUM_LANES
) (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  // Avalon-MM slave
  input  wire logic [`LSB_ADDR_W-1:0]      avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  // Lane side, one slice per lane starting at lane 1
  input  wire logic [NUM_LANES-1:0]        lane_soft_reset,
  input  wire lane_status_pkg::err_flags_t [NUM_LANES-1:0] err_event,
  input  wire lane_status_pkg::err_flags_t [NUM_LANES-1:0] count_hold_en,
  input  wire logic [NUM_LANES-1:0]        counter_clear,
  // Flags for other logic
  output lane_status_pkg::err_flags_t [NUM_LANES-1:0] count_full_flags
);
  import lane_status_pkg::*;

  // ----------------------------------------------------------------------
  // Per-lane error counters
  // ----------------------------------------------------------------------
  err_flags_t [NUM_LANES-1:0] lane_full;

  for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
    lane_err_counter u_cnt (
      .ref_clk       (ref_clk),
      .srst          (srst),
      .err_event     (err_event[l]),
      .hold_en       (count_hold_en[l]),
      .counter_clear (counter_clear[l]),
      .count_full    (lane_full[l])
    );
  end

  assign count_full_flags = lane_full;

  // ----------------------------------------------------------------------
  // Status bytes and bus slave
  // ----------------------------------------------------------------------
  bank_state_t      cur_ff;
  bank_state_t      nxt_cur;
  logic [11:0]      word_idx;
  logic [11:0]      lane_off;
  logic             hit;

  // Writes are accepted and dropped; every register here is read-only.
  assign word_idx = avs_address[`LSB_ADDR_W-1:2];
  assign lane_off = word_idx - `LSB_LANE1_STATUS_IDX;
  assign hit      = (word_idx >= `LSB_LANE1_STATUS_IDX)
                    && (lane_off < 12'(NUM_LANES));

  always_comb begin
    nxt_cur = cur_ff;
    for (int l = 0; l < NUM_LANES; l++) begin
      nxt_cur.status[l]                  = `LSB_STATUS_RESET;
      // A lane in soft reset is not operating, so its active bit reads 0.
      nxt_cur.status[l][`LSB_BIT_ACTIVE] = !lane_soft_reset[l];
      nxt_cur.status[l][`LSB_BIT_UNEXP_CTRL]   = lane_full[l][`LSB_BIT_UNEXP_CTRL];
      nxt_cur.status[l][`LSB_BIT_NOT_IN_TABLE] = lane_full[l][`LSB_BIT_NOT_IN_TABLE];
      nxt_cur.status[l][`LSB_BIT_BAD_DISP]     = lane_full[l][`LSB_BIT_BAD_DISP];
    end
    case (cur_ff.bus)
      bus_idle: begin
        if (avs_read || avs_write) begin
          nxt_cur.bus      = bus_ack;
          nxt_cur.readdata = 32'h0000_0000;
          if (avs_read && hit) begin
            nxt_cur.readdata[7:0] = cur_ff.status[lane_off[2:0]];
          end
        end
      end
      bus_ack: begin
        nxt_cur.bus = bus_idle;
      end
      default: begin
        nxt_cur.bus = bus_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Every access waits exactly one cycle so that read data comes from a flop.
  assign avs_waitrequest = (avs_read || avs_write) && (cur_ff.bus != bus_ack);
  assign avs_readdata    = cur_ff.readdata;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_wait_one_cycle: assert property (@(posedge ref_clk) disable iff (srst)
    (avs_read || avs_write) && avs_waitrequest && cur_ff.bus == bus_idle
    |=> !avs_waitrequest)
    else $error("access not answered after one wait cycle");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (srst)
    avs_read && !avs_waitrequest |-> avs_readdata[31:4] == 28'h0000000)
    else $error("reserved read data bits not zero");

  a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (srst)
    avs_read && avs_waitrequest && cur_ff.bus == bus_idle && !hit
    |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read did not return zero");

  a_lane1_read: assert property (@(posedge ref_clk) disable iff (srst)
    avs_read && avs_waitrequest && cur_ff.bus == bus_idle
    && word_idx == `LSB_LANE1_STATUS_IDX
    |=> avs_readdata[7:0] == $past(cur_ff.status[0]))
    else $error("lane 1 status read returned wrong byte");

  for (genvar l = 0; l < NUM_LANES; l++) begin : g_chk
    a_active_in_reset: assert property (@(posedge ref_clk) disable iff (srst)
      lane_soft_reset[l] |=> !cur_ff.status[l][3])
      else $error("active bit set while lane in soft reset");

    // The sampled reset keeps the edge that releases reset from expecting a loaded byte.
    a_active_running: assert property (@(posedge ref_clk) disable iff (srst)
      !srst && !lane_soft_reset[l] |=> cur_ff.status[l][3])
      else $error("active bit clear while lane enabled");

    a_flags_mapped: assert property (@(posedge ref_clk) disable iff (srst)
      1'b1 |=> cur_ff.status[l][2] == $past(lane_full[l][2])
               && cur_ff.status[l][1] == $past(lane_full[l][1])
               && cur_ff.status[l][0] == $past(lane_full[l][0]))
      else $error("status flag bits not mapped to their counters");

    a_status_high_zero: assert property (@(posedge ref_clk) disable iff (srst)
      cur_ff.status[l][7:4] == 4'h0)
      else $error("reserved status bits not zero");
  end

  c_read_mapped: cover property (@(posedge ref_clk) disable iff (srst)
    avs_read && !avs_waitrequest && avs_readdata[3]);
  c_read_flag: cover property (@(posedge ref_clk) disable iff (srst)
    avs_read && !avs_waitrequest && avs_readdata[2:0] != 3'h0);
  c_write_dropped: cover property (@(posedge ref_clk) disable iff (srst)
    avs_write && !avs_waitrequest && avs_byteenable != 4'h0 && avs_writedata != 32'h0);
  c_lane_in_reset: cover property (@(posedge ref_clk) disable iff (srst)
    lane_soft_reset[0] ##1 !lane_soft_reset[0]);
endmodule
`default_nettype wire

// ---- tb/lane_status_bank_tb.sv ----
// Self-checking bench for the per-lane error status bank.
`timescale 1ns/100ps
`default_nettype none
`include "lane_status_defines.svh"
module lane_status_bank_tb;
  import lane_status_pkg::*;
  logic                    ref_clk = 1'b0;
  logic                    srst = 1'b1;
  logic [`LSB_ADDR_W-1:0]  avs_address = '0;
  logic                    avs_read = 1'b0;
  logic                    avs_write = 1'b0;
  logic [31:0]             avs_writedata = '0;
  logic [3:0]              avs_byteenable = 4'hf;
  logic [31:0]             avs_readdata;
  logic                    avs_waitrequest;
  logic [4:0]              lane_soft_reset = 5'h1f;
  err_flags_t [4:0]        err_event = '0;
  err_flags_t [4:0]        count_hold_en = '0;
  logic [4:0]              counter_clear = '0;
  err_flags_t [4:0]        count_full_flags;
  logic [31:0]             rd;
  int                      n_mismatch = 0;
  int                      tests_run = 0;

  always #5 ref_clk = ~ref_clk;

  lane_status_bank #(.NUM_LANES(5)) lane_status_bank_inst (
    .ref_clk(ref_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .lane_soft_reset(lane_soft_reset), .err_event(err_event), .count_hold_en(count_hold_en),
    .counter_clear(counter_clear), .count_full_flags(count_full_flags));

  // ----------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic finish_test();
    $display("Mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  // The request is held until an edge samples waitrequest low; data is taken there.
  task automatic bus_access(input logic wr, input logic [13:0] a, input logic [31:0] wd,
                            output logic [31:0] d);
    int i;
    i = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge ref_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 50);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i >= 50) begin
      n_mismatch++;
      finish_test();
    end
  endtask

  task automatic read_lane(input int l, input logic [7:0] exp);
    bus_access(1'b0, 14'h1244 + 14'(4 * l), 32'h0, rd);
    check({24'h0, exp}, rd);
  endtask

  // Holds one error line high for exactly n sampling edges.
  task events(input int l, input int b, input int n);
    @(posedge ref_clk);
    err_event[l][b] <= 1'b1;
    repeat (n) @(posedge ref_clk);
    err_event[l][b] <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  // Runs one counter of one lane to its terminal count, past it, and back through a clear.
  task counter_case(input int l, input int b);
    count_hold_en[l][b] <= l[0];
    events(l, b, 254);
    check(32'h0, 32'(count_full_flags[l]));
    events(l, b, 1);
    check(32'h1 << b, 32'(count_full_flags[l]));
    read_lane(l, 8'h08 | (8'h01 << b));
    events(l, b, 3);
    check(32'h1 << b, 32'(count_full_flags[l]));
    @(posedge ref_clk);
    counter_clear[l] <= 1'b1;
    @(posedge ref_clk);
    counter_clear[l] <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check(32'h0, 32'(count_full_flags[l]));
    read_lane(l, 8'h08);
  endtask

  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    for (int l = 0; l < 5; l++) read_lane(l, 8'h00);
    lane_soft_reset <= 5'h04;
    repeat (2) @(posedge ref_clk);
    for (int l = 0; l < 5; l++) read_lane(l, (l == 2) ? 8'h00 : 8'h08);
    lane_soft_reset <= 5'h00;
    bus_access(1'b1, 14'h1248, 32'h0000_00ff, rd);
    read_lane(1, 8'h08);
    bus_access(1'b0, 14'h1240, 32'h0, rd);
    check(32'h0, rd);
    bus_access(1'b0, 14'h1258, 32'h0, rd);
    check(32'h0, rd);
    for (int l = 0; l < 5; l++) begin
      for (int b = 0; b < 3; b++) begin
        counter_case(l, b);
      end
    end
    // A reset in mid-run must clear a flag that no counter clear has touched.
    events(4, 0, 255);
    check(32'h1, 32'(count_full_flags[4]));
    srst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    check(32'h0, 32'(count_full_flags[4]));
    read_lane(4, 8'h08);
    finish_test();
  end
endmodule
`default_nettype wire
